// ### hdl/cfgj_consts.svh
`ifndef CFGJ_CONSTS_SVH
`define CFGJ_CONSTS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CFGJ_CLK_PERIOD_NS 100
`define CFGJ_RST_MIN_NS    320
`define CFGJ_USER_MIN_US   25
// least times round up to whole cycles
`define CFGJ_RST_MIN_CYC \
  ((`CFGJ_RST_MIN_NS + `CFGJ_CLK_PERIOD_NS - 1) / `CFGJ_CLK_PERIOD_NS)
`define CFGJ_USER_MIN_CYC \
  ((`CFGJ_USER_MIN_US * 1000 + `CFGJ_CLK_PERIOD_NS - 1) / `CFGJ_CLK_PERIOD_NS)
`define CFGJ_LOAD_CYC     32

// ----------------------------------------------------------------------
// test access port
// ----------------------------------------------------------------------
`define CFGJ_IR_W        4
`define CFGJ_IR_IDCODE   4'h1
`define CFGJ_IR_BYPASS   4'hF
`define CFGJ_IR_CAPTURE  4'h1
`define CFGJ_ID_W        32
// arbitrary identification value
`define CFGJ_ID_VALUE    32'h0000_0001

`endif

// ### hdl/cfgj_pkg.sv
`default_nettype none

package cfgj_pkg;

  // ----------------------------------------------------------------------
  // test access port controller states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CFGJ_TLR, CFGJ_RTI, CFGJ_SEL_DR, CFGJ_CAP_DR, CFGJ_SH_DR, CFGJ_EX1_DR,
    CFGJ_PA_DR, CFGJ_EX2_DR, CFGJ_UPD_DR, CFGJ_SEL_IR, CFGJ_CAP_IR,
    CFGJ_SH_IR, CFGJ_EX1_IR, CFGJ_PA_IR, CFGJ_EX2_IR, CFGJ_UPD_IR
  } cfgj_tap_t;

  // ----------------------------------------------------------------------
  // configuration sequence states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CFGJ_LOAD, CFGJ_RELEASE, CFGJ_USER
  } cfgj_cfg_t;

  // test port pin levels as seen at the pads
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } cfgj_jtag_t;

endpackage

`default_nettype wire

// ### hdl/cfgj_top.sv
`include "cfgj_consts.svh"
`default_nettype none

// Overview of operation
// - every config pin except test clock and test output is weakly pulled up; cfg_pullup_en_o is cleared in user mode
// - done line is open drain, reads 1 when configured, then user mode
// - an outside party holding done low delays user mode until released
// - reconfig trigger restarts configuration only, never resets user logic
// - test port samples mode select and data in on test clock rise
// - test data out changes only after test clock falling edge
// - undriven mode select and data in read as 1 via pull-up
// - data in shifts into instruction or selected data register, out likewise
// - test data out is high impedance whenever nothing is shifting
module cfgj_top (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  // test port pins
  input  wire cfgj_pkg::cfgj_jtag_t jtag_i,
  output var  logic                 tdo_o,
  output var  logic                 tdo_oe_o,
  // configuration pins
  input  wire logic                 creset_n_i,
  input  wire logic                 config_done_i,
  output var  logic                 config_done_o,
  output var  logic                 config_done_oe_o,
  // status towards the fabric
  output var  logic                 cfg_pullup_en_o,
  output var  logic                 jtag_pullup_en_o,
  output var  logic                 cfg_start_o,
  output var  logic                 user_mode_o,
  output var  logic                 user_ready_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] tck_q;
  logic [1:0] tms_q, tdi_q, crst_q, done_q;
  logic       crst_d3_q;

  // first stage of each chain feeds only its second stage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tck_q     <= 3'h7;
      tms_q     <= 2'h3;
      tdi_q     <= 2'h3;
      crst_q    <= 2'h3;
      crst_d3_q <= 1'h1;
      done_q    <= 2'h0;
    end else begin
      tck_q     <= {tck_q[1:0], jtag_i.tck};
      tms_q     <= {tms_q[0], jtag_i.tms};
      tdi_q     <= {tdi_q[0], jtag_i.tdi};
      crst_q    <= {crst_q[0], creset_n_i};
      crst_d3_q <= crst_q[1];
      done_q    <= {done_q[0], config_done_i};
    end
  end

  // edge detection on the second and third stages
  wire logic tck_rise  = tck_q[1] & ~tck_q[2];
  wire logic tck_fall  = ~tck_q[1] & tck_q[2];
  wire logic tms_s     = tms_q[1];
  wire logic tdi_s     = tdi_q[1];
  wire logic done_s    = done_q[1];
  wire logic crst_rise = crst_q[1] & ~crst_d3_q;

  // ----------------------------------------------------------------------
  // configuration sequence
  // ----------------------------------------------------------------------
  cfgj_pkg::cfgj_cfg_t cfg_q, cfg_d;
  logic [3:0]          low_cnt_q;
  logic [7:0]          load_cnt_q;
  logic [7:0]          user_cnt_q;

  // short low pulses are not taken as a reconfiguration request
  wire logic pulse_ok  = low_cnt_q >= 4'(`CFGJ_RST_MIN_CYC);
  wire logic reconfig  = crst_rise & pulse_ok;
  wire logic load_done = load_cnt_q == 8'(`CFGJ_LOAD_CYC - 1);
  wire logic user_done = user_cnt_q == 8'(`CFGJ_USER_MIN_CYC - 1);

  // next configuration state
  always_comb begin
    cfg_d = cfg_q;
    case (cfg_q)
      cfgj_pkg::CFGJ_LOAD:    if (load_done) cfg_d = cfgj_pkg::CFGJ_RELEASE;
      cfgj_pkg::CFGJ_RELEASE: if (done_s) cfg_d = cfgj_pkg::CFGJ_USER;
      default:                cfg_d = cfg_q;
    endcase
    if (reconfig) cfg_d = cfgj_pkg::CFGJ_LOAD;
  end

  // sequence state and counters
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_q      <= cfgj_pkg::CFGJ_LOAD;
      low_cnt_q  <= 4'h0;
      load_cnt_q <= 8'h00;
      user_cnt_q <= 8'h00;
    end else begin
      cfg_q      <= cfg_d;
      low_cnt_q  <= crst_q[1] ? 4'h0 :
                    (pulse_ok ? low_cnt_q : low_cnt_q + 4'h1);
      load_cnt_q <= (cfg_d == cfgj_pkg::CFGJ_LOAD && !reconfig) ?
                    load_cnt_q + 8'h01 : 8'h00;
      user_cnt_q <= (cfg_q == cfgj_pkg::CFGJ_USER && !user_done) ?
                    user_cnt_q + 8'h01 : user_cnt_q;
      if (cfg_q != cfgj_pkg::CFGJ_USER) user_cnt_q <= 8'h00;
    end
  end

  // pin drivers and status flags
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      config_done_o    <= 1'h0;
      config_done_oe_o <= 1'h1;
      cfg_pullup_en_o  <= 1'h1;
      jtag_pullup_en_o <= 1'h1;
      cfg_start_o      <= 1'h0;
      user_mode_o      <= 1'h0;
      user_ready_o     <= 1'h0;
    end else begin
      config_done_o    <= 1'h0;
      config_done_oe_o <= cfg_d == cfgj_pkg::CFGJ_LOAD;
      cfg_pullup_en_o  <= cfg_d != cfgj_pkg::CFGJ_USER;
      jtag_pullup_en_o <= 1'h1;
      cfg_start_o      <= reconfig;
      user_mode_o      <= cfg_d == cfgj_pkg::CFGJ_USER;
      user_ready_o     <= cfg_d == cfgj_pkg::CFGJ_USER && user_done;
    end
  end

  // ----------------------------------------------------------------------
  // test access port controller
  // ----------------------------------------------------------------------
  function automatic cfgj_pkg::cfgj_tap_t tap_next(
    input cfgj_pkg::cfgj_tap_t s, input logic m);
    case (s)
      cfgj_pkg::CFGJ_TLR:
        tap_next = m ? cfgj_pkg::CFGJ_TLR : cfgj_pkg::CFGJ_RTI;
      cfgj_pkg::CFGJ_RTI:
        tap_next = m ? cfgj_pkg::CFGJ_SEL_DR : cfgj_pkg::CFGJ_RTI;
      cfgj_pkg::CFGJ_SEL_DR:
        tap_next = m ? cfgj_pkg::CFGJ_SEL_IR : cfgj_pkg::CFGJ_CAP_DR;
      cfgj_pkg::CFGJ_CAP_DR:
        tap_next = m ? cfgj_pkg::CFGJ_EX1_DR : cfgj_pkg::CFGJ_SH_DR;
      cfgj_pkg::CFGJ_SH_DR:
        tap_next = m ? cfgj_pkg::CFGJ_EX1_DR : cfgj_pkg::CFGJ_SH_DR;
      cfgj_pkg::CFGJ_EX1_DR:
        tap_next = m ? cfgj_pkg::CFGJ_UPD_DR : cfgj_pkg::CFGJ_PA_DR;
      cfgj_pkg::CFGJ_PA_DR:
        tap_next = m ? cfgj_pkg::CFGJ_EX2_DR : cfgj_pkg::CFGJ_PA_DR;
      cfgj_pkg::CFGJ_EX2_DR:
        tap_next = m ? cfgj_pkg::CFGJ_UPD_DR : cfgj_pkg::CFGJ_SH_DR;
      cfgj_pkg::CFGJ_UPD_DR:
        tap_next = m ? cfgj_pkg::CFGJ_SEL_DR : cfgj_pkg::CFGJ_RTI;
      cfgj_pkg::CFGJ_SEL_IR:
        tap_next = m ? cfgj_pkg::CFGJ_TLR : cfgj_pkg::CFGJ_CAP_IR;
      cfgj_pkg::CFGJ_CAP_IR:
        tap_next = m ? cfgj_pkg::CFGJ_EX1_IR : cfgj_pkg::CFGJ_SH_IR;
      cfgj_pkg::CFGJ_SH_IR:
        tap_next = m ? cfgj_pkg::CFGJ_EX1_IR : cfgj_pkg::CFGJ_SH_IR;
      cfgj_pkg::CFGJ_EX1_IR:
        tap_next = m ? cfgj_pkg::CFGJ_UPD_IR : cfgj_pkg::CFGJ_PA_IR;
      cfgj_pkg::CFGJ_PA_IR:
        tap_next = m ? cfgj_pkg::CFGJ_EX2_IR : cfgj_pkg::CFGJ_PA_IR;
      cfgj_pkg::CFGJ_EX2_IR:
        tap_next = m ? cfgj_pkg::CFGJ_UPD_IR : cfgj_pkg::CFGJ_SH_IR;
      default:
        tap_next = m ? cfgj_pkg::CFGJ_SEL_DR : cfgj_pkg::CFGJ_RTI;
    endcase
  endfunction

  cfgj_pkg::cfgj_tap_t   tap_q;
  logic [`CFGJ_IR_W-1:0] ir_q, ir_sh_q;
  logic [`CFGJ_ID_W-1:0] id_sh_q;
  logic                  byp_q;

  // decoded shift paths
  wire logic sh_ir  = tap_q == cfgj_pkg::CFGJ_SH_IR;
  wire logic sh_dr  = tap_q == cfgj_pkg::CFGJ_SH_DR;
  wire logic sel_id = ir_q == `CFGJ_IR_IDCODE;
  wire logic dr_out = sel_id ? id_sh_q[0] : byp_q;

  // state and registers advance on test clock rise; reset by rst_n_i, and ir_q also reloads in test logic reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tap_q   <= cfgj_pkg::CFGJ_TLR;
      ir_q    <= `CFGJ_IR_IDCODE;
      ir_sh_q <= `CFGJ_IR_CAPTURE;
      id_sh_q <= `CFGJ_ID_VALUE;
      byp_q   <= 1'h0;
    end else if (tck_rise) begin
      tap_q <= tap_next(tap_q, tms_s);
      case (tap_q)
        cfgj_pkg::CFGJ_TLR:    ir_q <= `CFGJ_IR_IDCODE;
        cfgj_pkg::CFGJ_CAP_IR: ir_sh_q <= `CFGJ_IR_CAPTURE;
        cfgj_pkg::CFGJ_SH_IR:
          ir_sh_q <= {tdi_s, ir_sh_q[`CFGJ_IR_W-1:1]};
        cfgj_pkg::CFGJ_UPD_IR: ir_q <= ir_sh_q;
        cfgj_pkg::CFGJ_CAP_DR: begin
          id_sh_q <= `CFGJ_ID_VALUE;
          byp_q   <= 1'h0;
        end
        cfgj_pkg::CFGJ_SH_DR: begin
          if (sel_id) id_sh_q <= {tdi_s, id_sh_q[`CFGJ_ID_W-1:1]};
          else byp_q <= tdi_s;
        end
        default: ;
      endcase
    end
  end

  // output driven after test clock fall, released when idle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tdo_o    <= 1'h1;
      tdo_oe_o <= 1'h0;
    end else if (tck_fall) begin
      tdo_o    <= sh_ir ? ir_sh_q[0] : dr_out;
      tdo_oe_o <= sh_ir | sh_dr;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  done_drive_a: assert property ((cfg_q == cfgj_pkg::CFGJ_LOAD && !reconfig
    && !load_done) |=> config_done_oe_o && !config_done_o)
    else $error("done line not pulled low while loading");
  user_hold_a: assert property (!done_s && !user_mode_o |=>
    !user_mode_o)
    else $error("user mode entered while done line low");
  pullup_cfg_a: assert property (!user_mode_o |-> cfg_pullup_en_o)
    else $error("pull-up off outside user mode");
  reconfig_go_a: assert property (reconfig |=> cfg_q == cfgj_pkg::CFGJ_LOAD
    && cfg_start_o)
    else $error("accepted trigger did not restart load");
  short_pulse_a: assert property ((crst_rise && !pulse_ok && user_mode_o)
    |=> ##1 user_mode_o)
    else $error("short trigger pulse left user mode");
  tap_keep_a: assert property (reconfig && !tck_rise |=>
    $stable(tap_q))
    else $error("trigger disturbed test port");
  tap_rise_a: assert property (!tck_rise |=> $stable(tap_q))
    else $error("test port moved without clock rise");
  tdo_fall_a: assert property ($changed(tdo_oe_o) |-> $past(tck_fall))
    else $error("output enable changed off falling edge");
  tdo_idle_a: assert property (tck_fall && !sh_ir && !sh_dr |=>
    !tdo_oe_o)
    else $error("output driven while idle");
  ir_shift_a: assert property (tck_rise && sh_ir |=>
    ir_sh_q[`CFGJ_IR_W-1] == $past(tdi_s))
    else $error("instruction shift lost data");
  tms_reset_a: assert property ((tck_rise && tms_s
    && tap_q == cfgj_pkg::CFGJ_SEL_IR) |=> tap_q == cfgj_pkg::CFGJ_TLR)
    else $error("select-ir with mode high missed reset");
  user_ready_a: assert property (user_ready_o |-> user_mode_o)
    else $error("ready without user mode");

  reconfig_c: cover property (reconfig ##[1:300] user_mode_o);
  ready_c:    cover property ($rose(user_ready_o));
  shift_dr_c: cover property (sh_dr && tdo_oe_o);
  shift_ir_c: cover property (sh_ir && tdo_oe_o);

endmodule

`default_nettype wire

// ### verification/cfgj_host.sv
`default_nettype none

module cfgj_host (
  // clock
  input  wire logic                 core_clk_i,
  // test port
  input  wire logic                 tdo_i,
  input  wire logic                 tdo_oe_i,
  output var  cfgj_pkg::cfgj_jtag_t jtag_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic oe_all;

  // tck stands high between frames
  initial jtag_o = 3'h7;

  // one 800 ns period: tms and tdi move at the fall, tdo taken at the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(posedge core_clk_i);
    jtag_o <= '{tck: 1'h0, tms: tms, tdi: tdi};
    repeat (4) @(posedge core_clk_i);
    jtag_o.tck <= 1'h1;
    // tdo must already stand at the rise, as a real host samples it there
    #1;
    tdo = tdo_i;
    oe_all = oe_all & tdo_oe_i;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  // five ones reach test logic reset, then park in run test idle
  task automatic tlr();
    logic t;
    repeat (5) tick(1'h1, 1'h1, t);
    tick(1'h0, 1'h1, t);
  endtask

  // scan n bits lsb first through ir or dr, from idle back to idle
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout, output logic oe_s);
    logic t;
    dout = '0;
    tick(1'h1, 1'h1, t);
    if (ir) tick(1'h1, 1'h1, t);
    tick(1'h0, 1'h1, t);
    tick(1'h0, 1'h1, t);
    oe_all = 1'h1;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    oe_s = oe_all;
    tick(1'h1, 1'h1, t);
    tick(1'h0, 1'h1, t);
  endtask
endmodule

`default_nettype wire

// ### verification/testbench.sv
`include "cfgj_consts.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk, rst_n, creset_n, hold_low, done_w;
  cfgj_pkg::cfgj_jtag_t jtag;
  logic                 tdo, tdo_oe, done_o, done_oe, pu_cfg, pu_jtag;
  logic                 start, user, ready, oe;
  logic [31:0]          d;
  int                   error_cnt, tests_run;

  // open-drain done wire with its pull-up
  assign done_w = ~hold_low & (done_oe ? done_o : 1'h1);

  cfgj_top u_cfgj_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .jtag_i(jtag), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .creset_n_i(creset_n), .config_done_i(done_w),
    .config_done_o(done_o), .config_done_oe_o(done_oe),
    .cfg_pullup_en_o(pu_cfg), .jtag_pullup_en_o(pu_jtag),
    .cfg_start_o(start), .user_mode_o(user), .user_ready_o(ready)
  );

  cfgj_host u_cfgj_host (
    .core_clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .jtag_o(jtag)
  );

  // 100 ns clock
  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_reset();
    #1;
    chk("done pull", 1, done_oe);
    chk("done out", 0, done_o);
    chk("cfg pullup", 1, pu_cfg);
    chk("tdo oe", 0, tdo_oe);
  endtask

  task automatic t_boot();
    repeat (100) @(posedge clk);
    #1 chk("user held", 0, user);
    chk("done rel", 0, done_oe);
    chk("cfg pullup", 1, pu_cfg);
    @(posedge clk) hold_low <= 1'h0;
    repeat (5) @(posedge clk);
    #1 chk("user mode", 1, user);
    chk("cfg pullup", 0, pu_cfg);
    chk("jtag pullup", 1, pu_jtag);
    repeat (240) @(posedge clk);
    #1 chk("ready early", 0, ready);
    repeat (20) @(posedge clk);
    #1 chk("ready", 1, ready);
  endtask

  task automatic t_pulse(input int n, input logic acc);
    int cnt;
    cnt = 0;
    @(posedge clk) creset_n <= 1'h0;
    repeat (n) @(posedge clk);
    creset_n <= 1'h1;
    repeat (20) begin
      @(posedge clk);
      #1 cnt += start;
    end
    chk("start pulses", acc, cnt);
    chk("user after", !acc, user);
    chk("done pull", acc, done_oe);
    repeat (40) @(posedge clk);
    #1 chk("user back", 1, user);
  endtask

  task automatic t_tap();
    u_cfgj_host.tlr();
    chk("tdo idle", 0, tdo_oe);
    u_cfgj_host.shift(1'h0, 32, 32'h0, d, oe);
    chk("idcode", `CFGJ_ID_VALUE, d);
    chk("oe shift", 1, oe);
    chk("tdo idle", 0, tdo_oe);
    u_cfgj_host.shift(1'h1, 4, `CFGJ_IR_BYPASS, d, oe);
    chk("ir capture", `CFGJ_IR_CAPTURE, d[3:0]);
    t_pulse(4, 1'h1);
    u_cfgj_host.shift(1'h0, 2, 32'h1, d, oe);
    chk("bypass kept", 2'h2, d[1:0]);
  endtask

  // watchdog: the whole run needs about 100 us
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end

  // main sequence
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    creset_n = 1'h1;
    hold_low = 1'h1;
    error_cnt = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    t_reset();
    @(posedge clk) rst_n <= 1'h1;
    t_boot();
    t_pulse(3, 1'h0);
    t_tap();
    summarize();
  end
endmodule

`default_nettype wire
